//--- src/ddc_pkg.sv
// Shared constants, register map and carriers for one tuner and resampler channel
package ddc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets inside the channel address space
  localparam logic [7:0] ADDR_FREQ_LO = 8'h85;
  localparam logic [7:0] ADDR_FREQ_HI = 8'h86;
  localparam logic [7:0] ADDR_PHASE_OFFSET = 8'h87;
  localparam logic [7:0] ADDR_OSC_CTRL = 8'h88;
  localparam logic [7:0] ADDR_DECIM = 8'h90;
  localparam logic [7:0] ADDR_INTERP = 8'h91;
  localparam logic [7:0] ADDR_SCALE = 8'h92;

  ////////////////////////////////////////////////////////////////////////////
  // Field widths and positions
  localparam int DATA_W = 16;
  localparam int SAMPLE_W = 12;
  localparam int DECIM_W = 12;
  localparam int INTERP_W = 9;
  localparam int SCALE_W = 5;
  localparam int SCALE_REG_W = 10;
  localparam int SCALE_LOUD_LSB = 0;
  localparam int SCALE_QUIET_LSB = 5;
  localparam int CTRL_W = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;
  localparam logic [15:0] RST_PHASE_OFFSET = 16'h0000;
  localparam logic [CTRL_W-1:0] RST_CTRL = 9'h000;
  localparam logic [DECIM_W-1:0] RST_DECIM = 12'h000;
  localparam logic [INTERP_W-1:0] RST_INTERP = 9'h000;
  localparam logic [SCALE_REG_W-1:0] RST_SCALE = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic [1:0] sync_sel;
    logic input_sel;
    logic [1:0] reserved;
    logic clear_on_hop;
    logic amp_dither;
    logic phase_dither;
    logic bypass;
  } osc_ctrl_s;

  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } iq_s;

endpackage : ddc_pkg

//--- src/quad_osc.sv
// Quadrature oscillator: phase accumulator, offset, dither and sine lookup
`timescale 1ns/1ps
module quad_osc (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic [31:0] freq_shadow,
  input wire logic freq_load,
  input wire logic [15:0] phase_offset,
  input wire logic phase_dither,
  input wire logic amp_dither,
  input wire logic clear_on_hop,
  // Results
  output logic [31:0] freq_active,
  output logic signed [11:0] cos_out,
  output logic signed [11:0] sin_out
);

  logic [31:0] freq_reg, freq_next;
  logic [31:0] acc_reg, acc_next;
  logic [15:0] lfsr_reg, lfsr_next;
  logic signed [11:0] cos_reg, cos_next, sin_reg, sin_next;
  logic [15:0] phase;
  logic [3:0] idx;

  // Coarse sine table; sixteen points keep the lookup tiny
  function automatic logic signed [11:0] sine(input logic [3:0] k);
    logic [10:0] mag;
    mag = 11'h000;
    case (k[2:0])
      3'h0: mag = 11'h000;
      3'h1: mag = 11'h30F;
      3'h2: mag = 11'h5A7;
      3'h3: mag = 11'h763;
      3'h4: mag = 11'h7FF;
      3'h5: mag = 11'h763;
      3'h6: mag = 11'h5A7;
      3'h7: mag = 11'h30F;
      default: mag = 11'h000;
    endcase
    sine = k[3] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sine

  always_comb begin
    freq_next = freq_reg;
    acc_next = acc_reg + freq_reg;
    lfsr_next = {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
    if (freq_load) begin
      freq_next = freq_shadow;
      if (clear_on_hop) begin
        acc_next = 32'h0000_0000;
      end else begin
        acc_next = acc_reg + freq_reg;
      end
    end
    // Offset added after the accumulator, so a clear never touches it
    phase = acc_reg[31:16] + phase_offset;
    if (phase_dither) begin
      phase = phase + {4'h0, lfsr_reg[11:0]};
    end
    idx = phase[15:12];
    sin_next = sine(idx);
    cos_next = sine(idx + 4'h4);
    if (amp_dither) begin
      // Toggling the LSB randomises rounding without overflow risk
      sin_next[0] = sin_next[0] ^ lfsr_reg[0];
      cos_next[0] = cos_next[0] ^ lfsr_reg[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_reg <= ddc_pkg::RST_FREQ;
      acc_reg <= 32'h0000_0000;
      lfsr_reg <= 16'hACE1;
      cos_reg <= 12'h000;
      sin_reg <= 12'h000;
    end else begin
      freq_reg <= freq_next;
      acc_reg <= acc_next;
      lfsr_reg <= lfsr_next;
      cos_reg <= cos_next;
      sin_reg <= sin_next;
    end
  end

  assign freq_active = freq_reg;
  assign cos_out = cos_reg;
  assign sin_out = sin_reg;

endmodule : quad_osc

//--- src/resampling_comb_filter.sv
// Second-order resampling integrator-comb filter with input attenuation
`timescale 1ns/1ps
module resampling_comb_filter #(
  parameter int IN_W = 16,
  parameter int FRAC = 24,
  parameter int ACC_W = 56
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Settings
  input wire logic [11:0] decim_m1,
  input wire logic [8:0] interp_m1,
  input wire logic [4:0] scale,
  // Stream
  input wire logic signed [IN_W-1:0] in_data,
  input wire logic in_valid,
  output logic signed [IN_W-1:0] out_data,
  output logic out_valid
);

  logic [12:0] phase_reg, phase_next;
  logic signed [ACC_W-1:0] int1_reg, int1_next, int2_reg, int2_next;
  logic signed [ACC_W-1:0] v1_reg, v1_next, c1_reg, c1_next;
  logic signed [IN_W-1:0] out_reg, out_next;
  logic valid_reg, valid_next;
  logic signed [ACC_W-1:0] xs, tap, c1, c2;
  logic [12:0] l_fac, m_fac, sum, k1;
  logic [ACC_W+12:0] prod;

  always_comb begin
    l_fac = 13'(interp_m1) + 13'h0001;
    m_fac = 13'(decim_m1) + 13'h0001;
    // Attenuation by 2^scale, applied on every path incl. 1/1 bypass
    xs = (ACC_W'(in_data) <<< FRAC) >>> scale;
    phase_next = phase_reg;
    int1_next = int1_reg;
    int2_next = int2_reg;
    v1_next = v1_reg;
    c1_next = c1_reg;
    out_next = out_reg;
    valid_next = 1'b0;
    sum = 13'h0000;
    k1 = 13'h0000;
    prod = '0;
    tap = '0;
    c1 = '0;
    c2 = '0;
    if (in_valid) begin
      // One input stands for L stuffed slots: one nonzero then L-1 zeros
      int1_next = int1_reg + xs;
      int2_next = int2_reg + ACC_W'($signed(l_fac) * int1_next);
      if (phase_reg >= m_fac) begin
        phase_next = 13'h0000;
      end else begin
        sum = phase_reg + l_fac;
        phase_next = sum;
        if (sum >= m_fac) begin
          // Slot inside this group where the M-th stuffed sample lands
          k1 = m_fac - phase_reg;
          prod = 69'($signed({1'b0, k1}) * int1_next);
          tap = int2_reg + prod[ACC_W-1:0];
          c1 = tap - v1_reg;
          c2 = c1 - c1_reg;
          v1_next = tap;
          c1_next = c1;
          out_next = c2[FRAC+IN_W-1:FRAC];
          valid_next = 1'b1;
          phase_next = sum - m_fac;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase_reg <= 13'h0000;
      int1_reg <= '0;
      int2_reg <= '0;
      v1_reg <= '0;
      c1_reg <= '0;
      out_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      int1_reg <= int1_next;
      int2_reg <= int2_next;
      v1_reg <= v1_next;
      c1_reg <= c1_next;
      out_reg <= out_next;
      valid_reg <= valid_next;
    end
  end

  assign out_data = out_reg;
  assign out_valid = valid_reg;

endmodule : resampling_comb_filter

//--- src/ddc_channel_tuner_resampler.sv
// One receive channel: register file, input select, tuner and resampler
//
// Contract
// - A 16-bit unsigned phase offset is added to the accumulator phase.
// - Control bit 0 high skips down-conversion; channel filters complex data.
// - In bypass, port A feeds the I path and port B the Q path.
// - Control bit 1 adds phase dither against truncation spurs.
// - Control bit 2 randomises amplitude quantisation in the sine lookup.
// - Phase and amplitude dither are independent of each other.
// - Control bit 3 clears the accumulator at the next frequency change.
// - That clear leaves the phase offset untouched and applied.
// - Control bit 3 low gives phase-continuous hops.
// - Control bit 6 picks port B, else port A, for the channel.
// - Control bits 8:7 pick sync pin first, second, third or fourth.
// - Any pin may serve many channels; each channel follows one pin.
// - Resampler takes interpolation 1..512 and decimation 1..4096.
// - Resample by zero-stuffing by L, then a second-order integrator-comb.
// - Resampler runs at full input rate; output rate is input times L/M for L up to M.
// - L and M both one bypass rate change and filtering.
// - Input to the resampler is attenuated 6 dB per scale step, 0..31.
// - Scale attenuation applies even with the resampler bypassed.
// - Bits 9:5 apply with large-signal flag low, bits 4:0 with it high.
`timescale 1ns/1ps
module ddc_channel_tuner_resampler #(
  parameter int SAMPLE_W = ddc_pkg::SAMPLE_W,
  parameter int DATA_W = ddc_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Converter sample ports
  input wire logic signed [SAMPLE_W-1:0] port_a_data,
  input wire logic signed [SAMPLE_W-1:0] port_b_data,
  input wire logic port_valid,
  input wire logic large_signal_flag_a,
  input wire logic large_signal_flag_b,
  // Sync pins and frequency hop
  input wire logic sync_pin_first,
  input wire logic sync_pin_second,
  input wire logic sync_pin_third,
  input wire logic sync_pin_fourth,
  input wire logic freq_load,
  output logic channel_sync,
  // Resampled stream
  output ddc_pkg::iq_s iq_out,
  output logic iq_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] freq_shadow_reg, freq_shadow_next;
  logic [15:0] phase_offset_reg, phase_offset_next;
  ddc_pkg::osc_ctrl_s ctrl_reg, ctrl_next;
  logic [ddc_pkg::DECIM_W-1:0] decim_reg, decim_next;
  logic [ddc_pkg::INTERP_W-1:0] interp_reg, interp_next;
  logic [ddc_pkg::SCALE_REG_W-1:0] scale_reg, scale_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [31:0] freq_active;

  always_comb begin
    freq_shadow_next = freq_shadow_reg;
    phase_offset_next = phase_offset_reg;
    ctrl_next = ctrl_reg;
    decim_next = decim_reg;
    interp_next = interp_reg;
    scale_next = scale_reg;
    rdata_next = rdata_reg;
    if (reg_wr) begin
      case (reg_addr)
        ddc_pkg::ADDR_FREQ_LO: freq_shadow_next[15:0] = reg_wdata;
        ddc_pkg::ADDR_FREQ_HI: freq_shadow_next[31:16] = reg_wdata;
        ddc_pkg::ADDR_PHASE_OFFSET: phase_offset_next = reg_wdata;
        ddc_pkg::ADDR_OSC_CTRL: begin
          ctrl_next = ddc_pkg::osc_ctrl_s'(reg_wdata[ddc_pkg::CTRL_W-1:0]);
          // Reserved bits are not stored, whatever software writes
          ctrl_next.reserved = 2'h0;
        end
        ddc_pkg::ADDR_DECIM: decim_next = reg_wdata[ddc_pkg::DECIM_W-1:0];
        ddc_pkg::ADDR_INTERP: interp_next = reg_wdata[ddc_pkg::INTERP_W-1:0];
        ddc_pkg::ADDR_SCALE: scale_next = reg_wdata[ddc_pkg::SCALE_REG_W-1:0];
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        // Frequency reads return the active value, not the shadow
        ddc_pkg::ADDR_FREQ_LO: rdata_next = freq_active[15:0];
        ddc_pkg::ADDR_FREQ_HI: rdata_next = freq_active[31:16];
        ddc_pkg::ADDR_PHASE_OFFSET: rdata_next = phase_offset_reg;
        ddc_pkg::ADDR_OSC_CTRL: rdata_next = 16'(ctrl_reg);
        ddc_pkg::ADDR_DECIM: rdata_next = 16'(decim_reg);
        ddc_pkg::ADDR_INTERP: rdata_next = 16'(interp_reg);
        ddc_pkg::ADDR_SCALE: rdata_next = 16'(scale_reg);
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      freq_shadow_reg <= ddc_pkg::RST_FREQ;
      phase_offset_reg <= ddc_pkg::RST_PHASE_OFFSET;
      ctrl_reg <= ddc_pkg::osc_ctrl_s'(ddc_pkg::RST_CTRL);
      decim_reg <= ddc_pkg::RST_DECIM;
      interp_reg <= ddc_pkg::RST_INTERP;
      scale_reg <= ddc_pkg::RST_SCALE;
      rdata_reg <= 16'h0000;
    end else begin
      freq_shadow_reg <= freq_shadow_next;
      phase_offset_reg <= phase_offset_next;
      ctrl_reg <= ctrl_next;
      decim_reg <= decim_next;
      interp_reg <= interp_next;
      scale_reg <= scale_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sync pin choice

  logic sync_reg, sync_next;

  always_comb begin
    // One pin per channel; nothing stops other channels picking the same one
    case (ctrl_reg.sync_sel)
      2'h0: sync_next = sync_pin_first;
      2'h1: sync_next = sync_pin_second;
      2'h2: sync_next = sync_pin_third;
      2'h3: sync_next = sync_pin_fourth;
      default: sync_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  // Pin-sync enable lives outside this channel
  assign channel_sync = sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator

  logic signed [11:0] cos_val, sin_val;

  quad_osc u_osc (
    .core_clk(core_clk),
    .rst(rst),
    .freq_shadow(freq_shadow_reg),
    .freq_load(freq_load),
    .phase_offset(phase_offset_reg),
    .phase_dither(ctrl_reg.phase_dither),
    .amp_dither(ctrl_reg.amp_dither),
    .clear_on_hop(ctrl_reg.clear_on_hop),
    .freq_active(freq_active),
    .cos_out(cos_val),
    .sin_out(sin_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Input select, mixer and scale choice

  ddc_pkg::iq_s mix_reg, mix_next;
  logic mix_valid_reg, mix_valid_next;
  logic [4:0] scale_sel_reg, scale_sel_next;
  logic signed [SAMPLE_W-1:0] chan_in;
  logic signed [SAMPLE_W+11:0] prod_i, prod_q;
  logic flag_sel;

  always_comb begin
    chan_in = ctrl_reg.input_sel ? port_b_data : port_a_data;
    flag_sel = ctrl_reg.input_sel ? large_signal_flag_b : large_signal_flag_a;
    prod_i = chan_in * cos_val;
    prod_q = -(chan_in * sin_val);
    mix_next = mix_reg;
    mix_valid_next = port_valid;
    if (ctrl_reg.bypass) begin
      // Complex baseband data straight through, A on I and B on Q
      mix_next.i = {port_a_data, 4'h0};
      mix_next.q = {port_b_data, 4'h0};
    end else begin
      mix_next.i = prod_i[SAMPLE_W+10:SAMPLE_W-5];
      mix_next.q = prod_q[SAMPLE_W+10:SAMPLE_W-5];
    end
    // Scale follows the flag of the port this channel watches
    if (flag_sel) begin
      scale_sel_next = scale_reg[ddc_pkg::SCALE_LOUD_LSB +: ddc_pkg::SCALE_W];
    end else begin
      scale_sel_next = scale_reg[ddc_pkg::SCALE_QUIET_LSB +: ddc_pkg::SCALE_W];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mix_reg <= '0;
      mix_valid_reg <= 1'b0;
      scale_sel_reg <= 5'h00;
    end else begin
      mix_reg <= mix_next;
      mix_valid_reg <= mix_valid_next;
      scale_sel_reg <= scale_sel_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Resampler, one per path; both share settings so they stay in step

  logic valid_i, valid_q;
  logic signed [DATA_W-1:0] out_i, out_q;

  resampling_comb_filter #(.IN_W(DATA_W)) u_rs_i (
    .core_clk(core_clk),
    .rst(rst),
    .decim_m1(decim_reg),
    .interp_m1(interp_reg),
    .scale(scale_sel_reg),
    .in_data(mix_reg.i),
    .in_valid(mix_valid_reg),
    .out_data(out_i),
    .out_valid(valid_i)
  );

  resampling_comb_filter #(.IN_W(DATA_W)) u_rs_q (
    .core_clk(core_clk),
    .rst(rst),
    .decim_m1(decim_reg),
    .interp_m1(interp_reg),
    .scale(scale_sel_reg),
    .in_data(mix_reg.q),
    .in_valid(mix_valid_reg),
    .out_data(out_q),
    .out_valid(valid_q)
  );

  assign iq_out.i = out_i;
  assign iq_out.q = out_q;
  assign iq_valid = valid_i & valid_q;

endmodule : ddc_channel_tuner_resampler

//--- dv/adc_port_model.sv
// Converter sample port model feeding the channel at full rate
`timescale 1ns/1ps
module adc_port_model (
  // Clock
  input wire logic core_clk,
  // Requested sample pair and flags
  input wire logic [11:0] a_req,
  input wire logic [11:0] b_req,
  input wire logic [1:0] flag_req,
  // Sample ports
  output logic [11:0] port_a_data,
  output logic [11:0] port_b_data,
  output logic port_valid,
  output logic large_signal_flag_a,
  output logic large_signal_flag_b
);
  // Full rate only, the converter never pauses
  always @(negedge core_clk) begin
    port_a_data <= a_req;
    port_b_data <= b_req;
    port_valid <= 1'b1;
    large_signal_flag_a <= flag_req[0];
    large_signal_flag_b <= flag_req[1];
  end
endmodule : adc_port_model

//--- dv/ddc_channel_tuner_resampler_sva.sv
// Port-level checks for the tuner and resampler channel
`timescale 1ns/1ps
module ddc_channel_tuner_resampler_sva #(
  parameter int SAMPLE_W = ddc_pkg::SAMPLE_W,
  parameter int DATA_W = ddc_pkg::DATA_W
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Converter ports
  input wire logic signed [SAMPLE_W-1:0] port_a_data,
  input wire logic signed [SAMPLE_W-1:0] port_b_data,
  input wire logic port_valid,
  input wire logic large_signal_flag_a,
  input wire logic large_signal_flag_b,
  // Sync and hop
  input wire logic sync_pin_first,
  input wire logic sync_pin_second,
  input wire logic sync_pin_third,
  input wire logic sync_pin_fourth,
  input wire logic freq_load,
  input wire logic channel_sync,
  // Stream
  input wire ddc_pkg::iq_s iq_out,
  input wire logic iq_valid
);
  logic [8:0] ctrl_reg;
  logic [15:0] offs_reg;
  logic dec_one_reg;
  logic int_one_reg;
  logic [1:0] quiet_reg;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of the written settings
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_reg <= 9'h000;
      offs_reg <= 16'h0000;
      dec_one_reg <= 1'b1;
      int_one_reg <= 1'b1;
      quiet_reg <= 2'h0;
    end else begin
      quiet_reg <= reg_wr ? 2'h0 : (quiet_reg == 2'h3 ? 2'h3 : quiet_reg + 2'h1);
      if (reg_wr && reg_addr == ddc_pkg::ADDR_OSC_CTRL) ctrl_reg <= reg_wdata[8:0] & 9'h1CF;
      if (reg_wr && reg_addr == ddc_pkg::ADDR_PHASE_OFFSET) offs_reg <= reg_wdata;
      if (reg_wr && reg_addr == ddc_pkg::ADDR_DECIM) dec_one_reg <= reg_wdata[11:0] == 12'h000;
      if (reg_wr && reg_addr == ddc_pkg::ADDR_INTERP) int_one_reg <= reg_wdata[8:0] == 9'h000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_sync_first_pin: assert property (ctrl_reg[8:7] == 2'b00 |=> channel_sync == $past(sync_pin_first))
    else $error("channel sync does not follow the first pin");
  chk_sync_second_pin: assert property (ctrl_reg[8:7] == 2'b01 |=> channel_sync == $past(sync_pin_second))
    else $error("channel sync does not follow the second pin");
  chk_sync_third_pin: assert property (ctrl_reg[8:7] == 2'b10 |=> channel_sync == $past(sync_pin_third))
    else $error("channel sync does not follow the third pin");
  chk_sync_fourth_pin: assert property (ctrl_reg[8:7] == 2'b11 |=> channel_sync == $past(sync_pin_fourth))
    else $error("channel sync does not follow the fourth pin");
  chk_offset_read_back: assert property (reg_rd && !reg_wr && reg_addr == ddc_pkg::ADDR_PHASE_OFFSET |=> reg_rdata == $past(offs_reg))
    else $error("phase offset read back wrong");
  chk_ctrl_read_back: assert property (reg_rd && !reg_wr && reg_addr == ddc_pkg::ADDR_OSC_CTRL |=> reg_rdata == {7'h00, $past(ctrl_reg)})
    else $error("control read back wrong");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  chk_unity_full_rate: assert property (port_valid && dec_one_reg && int_one_reg && quiet_reg == 2'h3 && !reg_wr ##1 !reg_wr |-> ##1 iq_valid)
    else $error("unity rate output missing");
  // Main scenarios reached
  cover property (ctrl_reg[0] && iq_valid);
  cover property (freq_load ##3 iq_valid);
  cover property (reg_rd && reg_addr == ddc_pkg::ADDR_SCALE);
endmodule : ddc_channel_tuner_resampler_sva

//--- dv/ddc_channel_tuner_resampler_tb.sv
// Self-checking bench for the tuner and resampler channel
`timescale 1ns/1ps
module ddc_channel_tuner_resampler_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [11:0] a_req = 12'h400;
  logic [11:0] b_req = 12'hC00;
  logic [1:0] flag_req = 2'b00;
  logic [11:0] port_a_data;
  logic [11:0] port_b_data;
  logic port_valid;
  logic flag_a;
  logic flag_b;
  logic [3:0] pins = 4'h0;
  logic freq_load = 1'b0;
  logic channel_sync;
  ddc_pkg::iq_s iq_out;
  logic iq_valid;
  int bad_count = 0;
  int samples_checked = 0;
  always #50 core_clk = ~core_clk;
  adc_port_model adc_u (.core_clk(core_clk), .a_req(a_req), .b_req(b_req),
    .flag_req(flag_req), .port_a_data(port_a_data), .port_b_data(port_b_data),
    .port_valid(port_valid), .large_signal_flag_a(flag_a), .large_signal_flag_b(flag_b));
  ddc_channel_tuner_resampler dut_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_a_data(port_a_data), .port_b_data(port_b_data), .port_valid(port_valid),
    .large_signal_flag_a(flag_a), .large_signal_flag_b(flag_b),
    .sync_pin_first(pins[0]), .sync_pin_second(pins[1]), .sync_pin_third(pins[2]),
    .sync_pin_fourth(pins[3]), .freq_load(freq_load), .channel_sync(channel_sync),
    .iq_out(iq_out), .iq_valid(iq_valid));
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : settle
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string name);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    check(name, exp, reg_rdata);
  endtask : rd
  // Settings then a steady stream, then one output pair compared
  task automatic stream_chk(input logic [15:0] ctrl, input logic [15:0] scale,
      input logic [1:0] flags, input logic [15:0] ei, input logic [15:0] eq);
    wr(ddc_pkg::ADDR_OSC_CTRL, ctrl);
    wr(ddc_pkg::ADDR_SCALE, scale);
    flag_req = flags;
    settle(8);
    check("iq_out.i", ei, iq_out.i);
    check("iq_out.q", eq, iq_out.q);
  endtask : stream_chk
  // Output pulses over 48 inputs; window is whole periods so start phase drops out
  task automatic rate_chk(input logic [8:0] l_m1, input logic [11:0] m_m1, input int exp);
    int cnt;
    cnt = 0;
    wr(ddc_pkg::ADDR_INTERP, {7'h00, l_m1});
    wr(ddc_pkg::ADDR_DECIM, {4'h0, m_m1});
    settle(8);
    repeat (48) begin
      @(negedge core_clk);
      if (iq_valid === 1'b1) cnt++;
    end
    check("iq_valid count", 16'(exp), 16'(cnt));
  endtask : rate_chk
  task automatic hop(input logic [31:0] f);
    wr(ddc_pkg::ADDR_FREQ_LO, f[15:0]);
    wr(ddc_pkg::ADDR_FREQ_HI, f[31:16]);
    @(negedge core_clk);
    freq_load = 1'b1;
    @(negedge core_clk);
    freq_load = 1'b0;
  endtask : hop
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    rd(ddc_pkg::ADDR_PHASE_OFFSET, 16'h0000, "offset reset");
    rd(ddc_pkg::ADDR_OSC_CTRL, 16'h0000, "ctrl reset");
    rd(ddc_pkg::ADDR_SCALE, 16'h0000, "scale reset");
    rd(8'h00, 16'h0000, "unmapped");
    wr(ddc_pkg::ADDR_PHASE_OFFSET, 16'hFFFF);
    rd(ddc_pkg::ADDR_PHASE_OFFSET, 16'hFFFF, "offset");
    wr(ddc_pkg::ADDR_OSC_CTRL, 16'h01CF);
    rd(ddc_pkg::ADDR_OSC_CTRL, 16'h01CF, "ctrl");
    wr(ddc_pkg::ADDR_SCALE, 16'h03FF);
    rd(ddc_pkg::ADDR_SCALE, 16'h03FF, "scale");
    wr(ddc_pkg::ADDR_DECIM, 16'hFFFF);
    rd(ddc_pkg::ADDR_DECIM, 16'h0FFF, "decim");
    wr(ddc_pkg::ADDR_INTERP, 16'hFFFF);
    rd(ddc_pkg::ADDR_INTERP, 16'h01FF, "interp");
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      wr(ddc_pkg::ADDR_OSC_CTRL, 16'(k << 7));
      for (int p = 0; p < 4; p++) begin
        pins = 4'h1 << p;
        @(negedge core_clk);
        check("channel_sync", 16'(p == k), 16'(channel_sync));
      end
    end
    $display("test sync select done");
    rate_chk(9'h000, 12'h003, 12);
    rate_chk(9'h002, 12'h003, 36);
    rate_chk(9'h001, 12'h002, 32);
    rate_chk(9'h1FF, 12'hFFF, 6);
    rate_chk(9'h000, 12'h000, 48);
    $display("test rate change done");
    stream_chk(16'h0001, 16'h0000, 2'b00, 16'h4000, 16'hC000);
    stream_chk(16'h0041, 16'h0063, 2'b00, 16'h0800, 16'hF800);
    stream_chk(16'h0001, 16'h0002, 2'b01, 16'h1000, 16'hF000);
    stream_chk(16'h0001, 16'h0002, 2'b00, 16'h4000, 16'hC000);
    $display("test bypass and scale done");
    wr(ddc_pkg::ADDR_PHASE_OFFSET, 16'h0000);
    // Zero frequency and offset hold phase at zero: full-scale cosine, zero sine
    stream_chk(16'h0008, 16'h0000, 2'b00, 16'h3FF8, 16'h0000);
    hop(32'h1234_5678);
    rd(ddc_pkg::ADDR_FREQ_LO, 16'h5678, "active freq");
    settle(20);
    hop(32'h0000_0000);
    settle(6);
    check("i after clear", 16'h3FF8, iq_out.i);
    wr(ddc_pkg::ADDR_PHASE_OFFSET, 16'h4000);
    hop(32'h1234_5678);
    settle(20);
    hop(32'h0000_0000);
    settle(6);
    check("i quarter offset", 16'h0000, iq_out.i);
    wr(ddc_pkg::ADDR_PHASE_OFFSET, 16'h0000);
    b_req = 12'h200;
    wr(ddc_pkg::ADDR_OSC_CTRL, 16'h0048);
    settle(8);
    check("i from port b", 16'h1FFC, iq_out.i);
    $display("test oscillator done");
    summarize();
  end
  // Whole run needs about 520 cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    bad_count++;
    $display("watchdog expired");
    summarize();
  end
endmodule : ddc_channel_tuner_resampler_tb

bind ddc_channel_tuner_resampler ddc_channel_tuner_resampler_sva #(.SAMPLE_W(SAMPLE_W),
  .DATA_W(DATA_W)) chk_u (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .port_a_data(port_a_data), .port_b_data(port_b_data), .port_valid(port_valid),
  .large_signal_flag_a(large_signal_flag_a), .large_signal_flag_b(large_signal_flag_b),
  .sync_pin_first(sync_pin_first), .sync_pin_second(sync_pin_second),
  .sync_pin_third(sync_pin_third), .sync_pin_fourth(sync_pin_fourth),
  .freq_load(freq_load), .channel_sync(channel_sync), .iq_out(iq_out), .iq_valid(iq_valid));
